/* sofs_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SOFS_MAP_SVH
`define SOFS_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SOFS_CTRL_OFS     8'h00
`define SOFS_SRC_OFS      8'h04
`define SOFS_ACTD_OFS     8'h08
`define SOFS_THR_OFS      8'h0c
`define SOFS_TRIPD_OFS    8'h10
`define SOFS_INCFG_OFS    8'h14
`define SOFS_ERRT_OFS     8'h18
`define SOFS_STAT_OFS     8'h1c
`define SOFS_FREQ_OFS     8'h20

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SOFS_CTRL_MODE_LSB  0
`define SOFS_CTRL_LOCK_LSB  8
`define SOFS_CTRL_POL_BIT   16
`define SOFS_CTRL_OUTS_BIT  17

// ---------------------------------------------------------------
// Selector codes and reset values
// ---------------------------------------------------------------
`define SOFS_SEL_STO      5'h0a
`define SOFS_SEL_LIMITED  5'h0b
`define SOFS_SEL_MAXIMUM  5'h0c
`define SOFS_SEL_DIRPOS   5'h0d
`define SOFS_LOCK_OFF     5'h1f
`define SOFS_SRC_RST      8'h00
`define SOFS_ERRT_RST     32'h0000_0064
`define SOFS_INPUTS       4
`define SOFS_OUT_SEL      2'h2

`endif

/* sofs_pkg.sv */
// Types shared by the safety output function select block
package sofs_pkg;

	// Latch and trip state of one output
	typedef enum logic [1:0] {
		SOFS_IDLE    = 2'b00,
		SOFS_ARMING  = 2'b01,
		SOFS_TRIPPED = 2'b10
	} sofs_state_t;

	// Configuration carried into the output logic
	typedef struct packed {
		logic [4:0]  mode;
		logic [4:0]  lock;
		logic        pol_inv;
		logic [7:0]  src;
		logic [31:0] act_delay;
		logic [31:0] thr;
		logic [31:0] trip_delay;
	} sofs_cfg_t;

	// Per-input qualified levels and edges
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] rise;
	} sofs_in_t;

endpackage : sofs_pkg

/* sofs_input_cond.sv */
// Input synchroniser, edge/level qualifier and illegal-state timeout
`timescale 1ns/1ps
`include "sofs_map.svh"

module sofs_input_cond
	import sofs_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  in_pin,
	input  wire logic [3:0]  dynamic_mode,
	input  wire logic [31:0] error_timeout,
	input  wire logic [3:0]  illegal_pair,
	output sofs_in_t         in_q,
	output logic             input_error
);

	logic [3:0]  sync1_reg;
	logic [3:0]  sync2_reg;
	logic [3:0]  prev_reg;
	logic [31:0] err_cnt_reg;

	// ---------------------------------------------------------------
	// Two-stage synchroniser; first stage feeds only the second
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			prev_reg  <= 4'h0;
		end else begin
			sync1_reg <= in_pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// Dynamic inputs see only rising edges, static ones see levels
	genvar gi;
	generate
		for (gi = 0; gi < `SOFS_INPUTS; gi++) begin : g_in
			assign in_q.rise[gi]  = sync2_reg[gi] & ~prev_reg[gi];
			assign in_q.level[gi] = dynamic_mode[gi] ? in_q.rise[gi]
				: sync2_reg[gi];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Illegal combination must persist beyond the timeout to flag
	// ---------------------------------------------------------------
	logic illegal_now;
	assign illegal_now = (sync2_reg[1:0] == illegal_pair[1:0])
		& illegal_pair[3];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_cnt_reg <= 32'h0;
			input_error <= 1'b0;
		end else if (!illegal_now) begin
			err_cnt_reg <= 32'h0;
		end else if (err_cnt_reg >= error_timeout) begin
			input_error <= 1'b1;
		end else begin
			err_cnt_reg <= err_cnt_reg + 32'h1;
		end
	end

	a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		input_error |=> input_error)
		else $error("input error dropped");

endmodule : sofs_input_cond

/* sofs_top.sv */
// Safety output function selector with AXI4-Lite configuration
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sofs_map.svh"

module sofs_top
	import sofs_pkg::*;
(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [31:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [31:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic [3:0]         in_pin,
	input  wire logic signed [31:0] freq,
	input  wire logic               overspeed_fb,
	output logic                    chan_a,
	output logic                    chan_b,
	output logic                    input_error
);

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [7:0]  src_reg;
	logic [31:0] actd_reg;
	logic [31:0] thr_reg;
	logic [31:0] tripd_reg;
	logic [31:0] incfg_reg;
	logic [31:0] errt_reg;
	sofs_cfg_t   cfg;

	assign cfg.mode       = ctrl_reg[`SOFS_CTRL_MODE_LSB +: 5];
	assign cfg.lock       = ctrl_reg[`SOFS_CTRL_LOCK_LSB +: 5];
	assign cfg.pol_inv    = ctrl_reg[`SOFS_CTRL_POL_BIT];
	assign cfg.src        = src_reg;
	assign cfg.act_delay  = actd_reg;
	assign cfg.thr        = thr_reg;
	assign cfg.trip_delay = tripd_reg;

	// ---------------------------------------------------------------
	// AXI4-Lite write path: address and data taken in either order
	// ---------------------------------------------------------------
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg;

	// Capture channels, then perform one write and answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_data_reg   <= 32'h0;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg <= `SOFS_FREQ_OFS
					&& aw_addr_reg[1:0] == 2'b00) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Byte-lane merge helper
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// Register stores; status and frequency are read only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg  <= {27'h0, `SOFS_SEL_STO}
				| ({27'h0, `SOFS_LOCK_OFF} << `SOFS_CTRL_LOCK_LSB);
			src_reg   <= `SOFS_SRC_RST;
			actd_reg  <= 32'h0;
			thr_reg   <= 32'h0;
			tripd_reg <= 32'h0;
			incfg_reg <= 32'h0;
			errt_reg  <= `SOFS_ERRT_RST;
		end else if (wr_fire) begin
			case (aw_addr_reg)
				`SOFS_CTRL_OFS:  ctrl_reg  <= merge(ctrl_reg,
					w_data_reg, w_strb_reg);
				`SOFS_SRC_OFS:   src_reg   <= w_strb_reg[0]
					? w_data_reg[7:0] : src_reg;
				`SOFS_ACTD_OFS:  actd_reg  <= merge(actd_reg,
					w_data_reg, w_strb_reg);
				`SOFS_THR_OFS:   thr_reg   <= merge(thr_reg,
					w_data_reg, w_strb_reg);
				`SOFS_TRIPD_OFS: tripd_reg <= merge(tripd_reg,
					w_data_reg, w_strb_reg);
				`SOFS_INCFG_OFS: incfg_reg <= merge(incfg_reg,
					w_data_reg, w_strb_reg);
				`SOFS_ERRT_OFS:  errt_reg  <= merge(errt_reg,
					w_data_reg, w_strb_reg);
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read path: one cycle from address to data
	// ---------------------------------------------------------------
	sofs_state_t state_reg;
	logic        trip_out;
	logic [31:0] stat_word;

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr[7:0])
				`SOFS_CTRL_OFS:  s_axi_rdata <= ctrl_reg;
				`SOFS_SRC_OFS:   s_axi_rdata <= {24'h0, src_reg};
				`SOFS_ACTD_OFS:  s_axi_rdata <= actd_reg;
				`SOFS_THR_OFS:   s_axi_rdata <= thr_reg;
				`SOFS_TRIPD_OFS: s_axi_rdata <= tripd_reg;
				`SOFS_INCFG_OFS: s_axi_rdata <= incfg_reg;
				`SOFS_ERRT_OFS:  s_axi_rdata <= errt_reg;
				`SOFS_STAT_OFS:  s_axi_rdata <= stat_word;
				`SOFS_FREQ_OFS:  s_axi_rdata <= freq;
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Input conditioning
	// ---------------------------------------------------------------
	sofs_in_t in_q;

	sofs_input_cond u_in (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.in_pin        (in_pin),
		.dynamic_mode  (incfg_reg[3:0]),
		.error_timeout (errt_reg),
		.illegal_pair  (incfg_reg[11:8]),
		.in_q          (in_q),
		.input_error   (input_error)
	);

	// ---------------------------------------------------------------
	// Enable source, acknowledge and overspeed evaluation
	// ---------------------------------------------------------------
	logic       enable;
	logic       ack;
	logic       lock_en;
	logic       overspeed_raw;

	// Feedback output is another block on the same clock; no sync
	assign enable = (cfg.src[`SOFS_CTRL_OUTS_BIT - 16] &&
		cfg.mode == `SOFS_SEL_STO)
		? overspeed_fb
		: in_q.level[cfg.src[1:0]];
	// Selector value 31 marks the latch as unused
	assign lock_en = cfg.lock != `SOFS_LOCK_OFF;
	assign ack     = in_q.rise[cfg.lock[1:0]] && lock_en;
	// Magnitude only: direction of rotation is ignored
	assign overspeed_raw = ((freq < 0) ? -freq : freq)
		> $signed(cfg.thr);

	logic [31:0] dly_cnt_reg;
	logic        ovs_held;
	logic [31:0] os_cnt_reg;

	// Overspeed must persist for the trip delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			os_cnt_reg <= 32'h0;
		end else if (!overspeed_raw) begin
			os_cnt_reg <= 32'h0;
		end else if (os_cnt_reg < cfg.trip_delay) begin
			os_cnt_reg <= os_cnt_reg + 32'h1;
		end
	end
	assign ovs_held = overspeed_raw && os_cnt_reg >= cfg.trip_delay;

	// Trip cause and acknowledge window per selected function
	logic cause;
	logic ack_ok;
	always_comb begin
		cause  = 1'b0;
		ack_ok = 1'b0;
		case (cfg.mode)
			`SOFS_SEL_STO: begin
				cause  = enable;
				ack_ok = !enable;
			end
			`SOFS_SEL_LIMITED: begin
				cause  = enable && ovs_held;
				ack_ok = !overspeed_raw || !enable;
			end
			`SOFS_SEL_MAXIMUM: begin
				cause  = ovs_held;
				ack_ok = !overspeed_raw;
			end
			`SOFS_SEL_DIRPOS: begin
				cause  = enable && freq > 0;
				ack_ok = freq <= 0 || !enable;
			end
			default: begin
				cause  = 1'b0;
				ack_ok = 1'b1;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Trip state: arming delay, latch, acknowledge release
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg   <= SOFS_IDLE;
			dly_cnt_reg <= 32'h0;
		end else begin
			case (state_reg)
				SOFS_IDLE: begin
					dly_cnt_reg <= 32'h0;
					if (cause && cfg.mode == `SOFS_SEL_STO
						&& cfg.act_delay != 32'h0) begin
						state_reg <= SOFS_ARMING;
					end else if (cause) begin
						state_reg <= SOFS_TRIPPED;
					end
				end
				SOFS_ARMING: begin
					if (!cause) begin
						state_reg <= SOFS_IDLE;
					end else if (dly_cnt_reg + 32'h1 >= cfg.act_delay) begin
						state_reg <= SOFS_TRIPPED;
					end else begin
						dly_cnt_reg <= dly_cnt_reg + 32'h1;
					end
				end
				SOFS_TRIPPED: begin
					// Latched when lock is on: only acknowledge releases it; with lock off, cause going away releases it
					if (lock_en && ack && ack_ok) begin
						state_reg <= SOFS_IDLE;
					end else if (!lock_en && !cause) begin
						state_reg <= SOFS_IDLE;
					end
				end
				default: state_reg <= SOFS_IDLE;
			endcase
		end
	end

	assign trip_out  = state_reg == SOFS_TRIPPED;
	assign stat_word = {28'h0, input_error, trip_out, state_reg};

	// Channel pair: registered, same-sense or complementary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_a <= 1'b0;
			chan_b <= 1'b0;
		end else begin
			chan_a <= trip_out;
			chan_b <= cfg.pol_inv ? !trip_out : trip_out;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_arm_abort;
		state_reg == SOFS_ARMING ##0 !cause;
	endsequence

	a_arm_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		s_arm_abort |=> state_reg == SOFS_IDLE)
		else $error("pending trip not abandoned");

	a_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(trip_out && lock_en && !ack) |=> trip_out)
		else $error("latch released without ack");

	a_pol_pair: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (chan_b == ($past(cfg.pol_inv) ? !chan_a : chan_a)))
		else $error("channel pair polarity wrong");

	a_limited_en: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == SOFS_IDLE && cfg.mode == `SOFS_SEL_LIMITED
		&& !enable) |=> !trip_out)
		else $error("limited speed tripped while disabled");

	a_dir_ack: assert property (@(posedge aclk) disable iff (!aresetn)
		(trip_out && cfg.mode == `SOFS_SEL_DIRPOS && lock_en
		&& freq > 0 && enable) |=> trip_out)
		else $error("direction ack accepted while positive");

	a_max_ack: assert property (@(posedge aclk) disable iff (!aresetn)
		(trip_out && cfg.mode == `SOFS_SEL_MAXIMUM && lock_en
		&& overspeed_raw) |=> trip_out)
		else $error("maximum speed ack during overspeed");

	a_trip_dly: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == SOFS_IDLE && cfg.mode == `SOFS_SEL_MAXIMUM
		&& !ovs_held) |=> !trip_out)
		else $error("overspeed trip before delay");

	a_no_early: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == SOFS_ARMING && dly_cnt_reg + 32'h1 < cfg.act_delay)
		|=> state_reg != SOFS_TRIPPED)
		else $error("safe stop tripped early");

endmodule : sofs_top

/* sofs_far_model.sv */
// Far-side model: encoder frequency, control switches, actuator pair
`timescale 1ns/1ps

module sofs_far_model (
	input  wire logic               aclk,
	input  wire logic signed [31:0] cmd_freq,
	input  wire logic [3:0]         cmd_in,
	input  wire logic               cmd_ovs,
	input  wire logic               pol_inv,
	input  wire logic               chan_a,
	input  wire logic               chan_b,
	output logic signed [31:0]      freq,
	output logic [3:0]              in_pin,
	output logic                    overspeed_fb,
	output logic                    pair_ok
);
	// -----------------------------------------------------------
	// Encoder evaluation and switches
	// -----------------------------------------------------------
	// Known levels at time zero, the design samples from reset on
	initial begin
		freq = '0;
		in_pin = '0;
		overspeed_fb = 1'b0;
	end

	// New speed figure once per cycle, like a gate-time evaluator
	always @(posedge aclk) begin
		freq <= cmd_freq;
		in_pin <= cmd_in;
		overspeed_fb <= cmd_ovs;
	end

	// Actuator only trusts a pair that matches the chosen polarity
	assign pair_ok = pol_inv ? (chan_a != chan_b) : (chan_a == chan_b);
endmodule : sofs_far_model

/* safety_output_function_select_tb.sv */
// Self-checking bench for the safety output function selector
`timescale 1ns/1ps
`include "sofs_map.svh"

module safety_output_function_select_tb;
	logic               aclk, aresetn, pol, ovs, chan_a, chan_b;
	logic               awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready, in_err, pair_ok;
	logic [31:0]        awaddr, wdata, araddr, rdata, rnd;
	logic [1:0]         bresp, rresp;
	logic signed [31:0] cmd_freq, freq;
	logic [3:0]         cmd_in, in_pin;
	logic               cmd_ovs;
	logic [31:0]        exp_q[$], msk_q[$];
	logic [1:0]         rsp_q[$];
	int                 miscompares, compares;

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	sofs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .in_pin(in_pin), .freq(freq),
		.overspeed_fb(ovs), .chan_a(chan_a), .chan_b(chan_b),
		.input_error(in_err));

	sofs_far_model u_far (.aclk(aclk), .cmd_freq(cmd_freq), .cmd_in(cmd_in),
		.cmd_ovs(cmd_ovs), .pol_inv(pol), .chan_a(chan_a), .chan_b(chan_b),
		.freq(freq), .in_pin(in_pin), .overspeed_fb(ovs), .pair_ok(pair_ok));

	// -----------------------------------------------------------
	// Checking and closing
	// -----------------------------------------------------------
	task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
		compares++;
		if (seen !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, e, seen);
		end
	endtask : check

	task stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	// Read answers are judged here, against the oldest note
	always @(negedge aclk) begin
		if (rvalid && rready && exp_q.size() > 0) begin
			check("rdata", rdata & msk_q[0], exp_q[0]);
			check("rresp", {30'h0, rresp}, {30'h0, rsp_q[0]});
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
			void'(rsp_q.pop_front());
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// -----------------------------------------------------------
	// Bus and pin drivers
	// -----------------------------------------------------------
	// Ready is sampled at the falling edge, so a combinational ready
	// that moves right after the rising edge cannot race the master
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw_h, w_h, b_h;
		b_h = 1'b0;
		n = 0;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_h && n < 50) begin
			@(negedge aclk);
			aw_h = awvalid && awready;
			w_h = wvalid && wready;
			b_h = bvalid;
			if (b_h) check("bresp", {30'h0, bresp}, {30'h0, er});
			@(posedge aclk);
			if (aw_h) awvalid <= 1'b0;
			if (w_h) wvalid <= 1'b0;
			if (b_h) bready <= 1'b0;
			n++;
		end
		if (!b_h) check("bvalid", 32'h0, 32'h1);
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		int n;
		logic ar_h, r_h;
		r_h = 1'b0;
		n = 0;
		exp_q.push_back(e);
		msk_q.push_back(m);
		rsp_q.push_back(er);
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_h && n < 50) begin
			@(negedge aclk);
			ar_h = arvalid && arready;
			r_h = rvalid;
			@(posedge aclk);
			if (ar_h) arvalid <= 1'b0;
			if (r_h) rready <= 1'b0;
			n++;
		end
		if (!r_h) check("rvalid", 32'h0, 32'h1);
	endtask : axi_rd

	function automatic logic [31:0] cfg(input logic [4:0] md, input logic [4:0] lk,
		input logic pi);
		return {15'h0, pi, 3'h0, lk, 3'h0, md};
	endfunction : cfg

	task out_is(input logic e);
		check("chan_a", {31'h0, chan_a}, {31'h0, e});
		check("chan_b", {31'h0, chan_b}, {31'h0, e ^ pol});
		check("pair_ok", {31'h0, pair_ok}, 32'h1);
	endtask : out_is

	// Bounded wait for a change of the output, then the comparison
	task wait_out(input logic e, input int n);
		int k;
		k = 0;
		do begin
			@(negedge aclk);
			k++;
		end while (chan_a !== e && k < n);
		out_is(e);
	endtask : wait_out

	task stay(input logic e, input int n);
		repeat (n) @(negedge aclk);
		out_is(e);
	endtask : stay

	task setin(input int i, input logic v);
		@(posedge aclk);
		cmd_in[i] <= v;
	endtask : setin

	task fr(input logic signed [31:0] v);
		@(posedge aclk);
		cmd_freq <= v;
	endtask : fr

	// Acknowledge is a rising edge on input 3, long enough to pass sync
	task ack;
		setin(3, 1'b1);
		repeat (6) @(posedge aclk);
		setin(3, 1'b0);
		repeat (6) @(posedge aclk);
	endtask : ack

	// -----------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, pol} = '0;
		{awaddr, wdata, araddr} = '0;
		cmd_freq = '0;
		cmd_in = '0;
		cmd_ovs = 1'b0;
		aresetn = 1'b0;
		rnd = 32'hd2a6;
		miscompares = 0;
		compares = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(`SOFS_CTRL_OFS, 32'h0000_1f0a, 32'h0001_1f1f, 2'b00);
		axi_rd(`SOFS_ERRT_OFS, `SOFS_ERRT_RST, 32'hffff_ffff, 2'b00);
		axi_rd(`SOFS_SRC_OFS, 32'h0, 32'h3, 2'b00);
		axi_rd(8'h40, 32'h0, 32'hffff_ffff, 2'b10);
		axi_wr(8'h44, 32'h1234_5678, 2'b10);
		out_is(1'b0);
		check("input_error", {31'h0, in_err}, 32'h0);
		repeat (4) begin
			rnd = lfsr(rnd);
			axi_wr(`SOFS_THR_OFS, rnd, 2'b00);
			axi_rd(`SOFS_THR_OFS, rnd, 32'hffff_ffff, 2'b00);
		end
		axi_wr(`SOFS_THR_OFS, 32'd1000, 2'b00);
		axi_wr(`SOFS_TRIPD_OFS, 32'd8, 2'b00);
		axi_wr(`SOFS_ACTD_OFS, 32'd40, 2'b00);
		axi_wr(`SOFS_SRC_OFS, 32'h0, 2'b00);
		$display("test registers done");
		// Delayed stop with latch; high speed must not matter
		axi_wr(`SOFS_CTRL_OFS, cfg(`SOFS_SEL_STO, 5'h03, 1'b0), 2'b00);
		fr(5000);
		setin(0, 1'b1);
		stay(1'b0, 20);
		setin(0, 1'b0);
		stay(1'b0, 60);
		setin(0, 1'b1);
		stay(1'b0, 25);
		wait_out(1'b1, 40);
		axi_rd(`SOFS_STAT_OFS, 32'h4, 32'h4, 2'b00);
		setin(0, 1'b0);
		stay(1'b1, 20);
		ack;
		wait_out(1'b0, 30);
		$display("test safe_stop_one done");
		// Limited speed, inverse pair
		axi_wr(`SOFS_CTRL_OFS, cfg(`SOFS_SEL_LIMITED, 5'h03, 1'b1), 2'b00);
		pol = 1'b1;
		fr(-1500);
		stay(1'b0, 30);
		setin(0, 1'b1);
		stay(1'b0, 4);
		wait_out(1'b1, 30);
		ack;
		stay(1'b1, 5);
		fr(500);
		ack;
		wait_out(1'b0, 20);
		fr(1500);
		wait_out(1'b1, 30);
		setin(0, 1'b0);
		ack;
		wait_out(1'b0, 20);
		$display("test limited_speed done");
		// Maximum speed, enable left off throughout
		axi_wr(`SOFS_CTRL_OFS, cfg(`SOFS_SEL_MAXIMUM, 5'h03, 1'b0), 2'b00);
		pol = 1'b0;
		rnd = lfsr(rnd);
		fr(32'sd1001 + $signed({20'h0, rnd[11:0]}));
		wait_out(1'b1, 30);
		ack;
		stay(1'b1, 5);
		fr(100);
		ack;
		wait_out(1'b0, 20);
		fr(-2000);
		wait_out(1'b1, 30);
		fr(0);
		ack;
		wait_out(1'b0, 20);
		axi_wr(`SOFS_CTRL_OFS, cfg(`SOFS_SEL_MAXIMUM, 5'h1f, 1'b0), 2'b00);
		fr(3000);
		stay(1'b0, 8);
		wait_out(1'b1, 30);
		fr(0);
		wait_out(1'b0, 30);
		$display("test maximum_speed done");
		// Long reverse run first, so a position sum would stay negative
		axi_wr(`SOFS_CTRL_OFS, cfg(`SOFS_SEL_DIRPOS, 5'h03, 1'b0), 2'b00);
		fr(-100);
		setin(0, 1'b1);
		stay(1'b0, 60);
		fr(1);
		wait_out(1'b1, 30);
		ack;
		stay(1'b1, 5);
		fr(0);
		ack;
		wait_out(1'b0, 20);
		setin(0, 1'b0);
		$display("test direction done");
		// Second output's overspeed feedback as enable, latched here
		axi_wr(`SOFS_SRC_OFS, 32'h2, 2'b00);
		axi_wr(`SOFS_CTRL_OFS, cfg(`SOFS_SEL_STO, 5'h03, 1'b0), 2'b00);
		@(posedge aclk);
		cmd_ovs <= 1'b1;
		stay(1'b0, 20);
		wait_out(1'b1, 40);
		@(posedge aclk);
		cmd_ovs <= 1'b0;
		stay(1'b1, 10);
		ack;
		wait_out(1'b0, 30);
		$display("test overspeed_enable done");
		// Illegal pattern on inputs 1:0, short then beyond the timeout
		axi_wr(`SOFS_INCFG_OFS, 32'h0000_0b00, 2'b00);
		axi_wr(`SOFS_ERRT_OFS, 32'd20, 2'b00);
		@(posedge aclk);
		cmd_in <= 4'h3;
		repeat (10) @(posedge aclk);
		cmd_in <= 4'h0;
		repeat (40) @(negedge aclk);
		check("input_error", {31'h0, in_err}, 32'h0);
		@(posedge aclk);
		cmd_in <= 4'h3;
		repeat (40) @(negedge aclk);
		check("input_error", {31'h0, in_err}, 32'h1);
		axi_rd(`SOFS_STAT_OFS, 32'h8, 32'h8, 2'b00);
		$display("test input_error done");
		stop_test;
	end

	// Whole run is under a thousand cycles; this is far beyond
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		stop_test;
	end
endmodule : safety_output_function_select_tb
